// >>> psr_pkg.sv
// shared constants and types for the packed simd register file
package psr_pkg;
	localparam int PSR_NUM_REGS = 8;
	localparam int PSR_REG_W = 64;
	localparam int PSR_IDX_W = 3;
	localparam int PSR_HALF_W = 32;
	localparam int PSR_BYTE_W = 8;
	localparam int PSR_NUM_SIZES = 4;
	localparam int PSR_INSTR_COUNT = 57;
	localparam logic [63:0] PSR_REG_RESET = 64'h0;
	localparam logic [31:0] PSR_HALF_ZERO = 32'h0;

	// lane size: bytes, words, doublewords, quadword
	typedef enum logic [1:0] {
		PSR_SZ_BYTE,
		PSR_SZ_WORD,
		PSR_SZ_DWORD,
		PSR_SZ_QWORD
	} psr_size_t;

	typedef enum logic [3:0] {
		PSR_OP_MOVE_Q,
		PSR_OP_MOVE_D,
		PSR_OP_STORE_Q,
		PSR_OP_STORE_D,
		PSR_OP_ADD,
		PSR_OP_ADD_SS,
		PSR_OP_ADD_US,
		PSR_OP_SUB,
		PSR_OP_SUB_SS,
		PSR_OP_SUB_US,
		PSR_OP_AND,
		PSR_OP_ANDN,
		PSR_OP_OR,
		PSR_OP_XOR,
		PSR_OP_CMP_EQ,
		PSR_OP_CMP_GT
	} psr_op_t;
endpackage

// >>> psr_register_file.sv
// packed simd register file aliased with the fp data stack, with lane alu
// ----------------------------------------------------------------------
module psr_register_file
	import psr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic op_valid,
	input wire psr_op_t op_code,
	input wire psr_size_t op_size,
	input wire logic [PSR_IDX_W-1:0] dst_idx,
	input wire logic [PSR_IDX_W-1:0] src_idx,
	input wire logic src_is_ext,
	input wire logic [PSR_REG_W-1:0] ext_data,
	input wire logic fp_wr_en,
	input wire logic [PSR_IDX_W-1:0] fp_wr_idx,
	input wire logic [PSR_REG_W-1:0] fp_wr_data,
	input wire logic [PSR_IDX_W-1:0] fp_rd_idx,
	output logic res_valid,
	output logic [PSR_REG_W-1:0] res_data,
	output logic [PSR_REG_W-1:0] fp_rd_data
);
	// ------------------------------------------------------------------
	// operand fetch
	// ------------------------------------------------------------------
	logic [PSR_REG_W-1:0] regs [PSR_NUM_REGS];
	logic [PSR_REG_W-1:0] next_regs [PSR_NUM_REGS];
	logic [PSR_REG_W-1:0] opa;
	logic [PSR_REG_W-1:0] opb;
	wire logic [PSR_REG_W-1:0] lane_res [PSR_NUM_SIZES];
	logic [PSR_REG_W-1:0] alu_res;
	logic [PSR_REG_W-1:0] next_res_data;
	logic [PSR_REG_W-1:0] next_fp_rd_data;
	logic next_res_valid;
	logic accepted;

	function automatic logic op_writes(input psr_op_t op);
		op_writes = (op != PSR_OP_STORE_Q) && (op != PSR_OP_STORE_D);
	endfunction

	assign accepted = ce && op_valid;
	// destination is also the first source; index picks a register directly
	assign opa = regs[dst_idx];
	assign opb = src_is_ext ? ext_data : regs[src_idx];

	// ------------------------------------------------------------------
	// lane alu, one slice per lane size
	// ------------------------------------------------------------------
	for (genvar g = 0; g < PSR_NUM_SIZES; g++)
	begin : g_size
		localparam int W = PSR_BYTE_W << g;
		localparam int N = PSR_NUM_REGS >> g;
		for (genvar l = 0; l < N; l++)
		begin : g_lane
			logic [W-1:0] x;
			logic [W-1:0] y;
			logic [W:0] sum;
			logic [W:0] dif;
			logic [W-1:0] q;
			logic s_ovf;
			logic d_ovf;
			logic [W-1:0] smax;
			logic [W-1:0] smin;
			assign x = opa[l*W +: W];
			assign y = opb[l*W +: W];
			assign sum = {1'b0, x} + {1'b0, y};
			assign dif = {1'b0, x} - {1'b0, y};
			assign s_ovf = (x[W-1] == y[W-1]) && (sum[W-1] != x[W-1]);
			assign d_ovf = (x[W-1] != y[W-1]) && (dif[W-1] != x[W-1]);
			assign smax = {1'b0, {(W-1){1'b1}}};
			assign smin = {1'b1, {(W-1){1'b0}}};
			always_comb
			begin
				// carries leave the lane and set nothing
				case (op_code)
					PSR_OP_ADD: q = sum[W-1:0];
					PSR_OP_SUB: q = dif[W-1:0];
					PSR_OP_ADD_SS: q = s_ovf ? (x[W-1] ? smin : smax) : sum[W-1:0];
					PSR_OP_SUB_SS: q = d_ovf ? (x[W-1] ? smin : smax) : dif[W-1:0];
					PSR_OP_ADD_US: q = sum[W] ? {W{1'b1}} : sum[W-1:0];
					PSR_OP_SUB_US: q = dif[W] ? {W{1'b0}} : dif[W-1:0];
					PSR_OP_CMP_EQ: q = {W{x == y}};
					PSR_OP_CMP_GT: q = {W{$signed(x) > $signed(y)}};
					default: q = x;
				endcase
			end
			assign lane_res[g][l*W +: W] = q;
		end
	end

	always_comb
	begin
		// the instruction casts the register to its lane size
		case (op_code)
			PSR_OP_MOVE_Q: alu_res = opb;
			PSR_OP_STORE_Q: alu_res = opa;
			PSR_OP_MOVE_D: alu_res = {PSR_HALF_ZERO, opb[PSR_HALF_W-1:0]};
			PSR_OP_STORE_D: alu_res = {PSR_HALF_ZERO, opa[PSR_HALF_W-1:0]};
			PSR_OP_AND: alu_res = opa & opb;
			PSR_OP_ANDN: alu_res = ~opa & opb;
			PSR_OP_OR: alu_res = opa | opb;
			PSR_OP_XOR: alu_res = opa ^ opb;
			default: alu_res = lane_res[op_size];
		endcase
	end

	// ------------------------------------------------------------------
	// shared storage update
	// ------------------------------------------------------------------
	always_comb
	begin
		next_regs = regs;
		next_res_valid = res_valid;
		next_res_data = res_data;
		next_fp_rd_data = fp_rd_data;
		if (ce)
		begin
			// fp stack writes land in the same cells; simd write wins a tie
			if (fp_wr_en)
				next_regs[fp_wr_idx] = fp_wr_data;
			if (accepted && op_writes(op_code))
				next_regs[dst_idx] = alu_res;
			next_res_valid = accepted;
			// register values leave only as result data or fp read data, never as an address
			next_res_data = accepted ? alu_res : res_data;
			next_fp_rd_data = regs[fp_rd_idx];
		end
	end

	// no mode bits and no flags exist beyond the storage itself
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < PSR_NUM_REGS; i++)
				regs[i] <= PSR_REG_RESET;
			res_valid <= 1'b0;
			res_data <= PSR_REG_RESET;
			fp_rd_data <= PSR_REG_RESET;
		end
		else
		begin
			regs <= next_regs;
			res_valid <= next_res_valid;
			res_data <= next_res_data;
			fp_rd_data <= next_fp_rd_data;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	logic [PSR_IDX_W-1:0] last_dst;
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			last_dst <= '0;
		else if (accepted)
			last_dst <= dst_idx;
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	half_write_clear_a: assert property (
		accepted && op_code == PSR_OP_MOVE_D
		|=> res_data[63:32] == 32'h0 && regs[last_dst] == res_data)
		else $error("half-width write left upper doubleword set");
	byte_wrap_a: assert property (
		accepted && op_code == PSR_OP_ADD && op_size == PSR_SZ_BYTE
		|=> res_data[7:0] == 8'($past(opa[7:0]) + $past(opb[7:0])))
		else $error("byte lane zero wrap sum wrong");
	word_lane_a: assert property (
		accepted && op_code == PSR_OP_ADD && op_size == PSR_SZ_WORD
		|=> res_data[63:48] == 16'($past(opa[63:48]) + $past(opb[63:48])))
		else $error("top word lane sum wrong");
	dword_lane_a: assert property (
		accepted && op_code == PSR_OP_SUB && op_size == PSR_SZ_DWORD
		|=> res_data[63:32] == 32'($past(opa[63:32]) - $past(opb[63:32])))
		else $error("upper doubleword difference wrong");
	signed_sat_a: assert property (
		accepted && op_code == PSR_OP_ADD_SS && op_size == PSR_SZ_BYTE
		&& opa[55:48] == 8'h7F && opb[55:48] == 8'h01
		|=> res_data[55:48] == 8'h7F)
		else $error("signed byte lane six did not saturate");
	store_image_a: assert property (
		accepted && op_code == PSR_OP_STORE_Q |=> res_data == $past(opa))
		else $error("stored image differs from register");
	fp_alias_a: assert property (
		ce && fp_wr_en && !(accepted && op_writes(op_code)
		&& dst_idx == fp_wr_idx)
		|=> regs[$past(fp_wr_idx)] == $past(fp_wr_data))
		else $error("fp stack write not seen in simd register");
	result_pulse_a: assert property (
		accepted |=> res_valid)
		else $error("result valid missing after accepted op");
	result_idle_a: assert property (
		$past(ce) && !$past(accepted) |-> !res_valid)
		else $error("result valid without accepted op");

	cover_sat_c: cover property (
		accepted && op_code == PSR_OP_ADD_US ##1 res_valid);
	cover_alias_c: cover property (
		ce && fp_wr_en ##1 accepted && op_code == PSR_OP_STORE_Q);
	cover_half_c: cover property (
		accepted && op_code == PSR_OP_MOVE_D ##1 res_valid);
endmodule

// >>> psr_lsu_model.sv
// load/store unit model that catches quadword store images in a byte memory
module psr_lsu_model
	import psr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic ce,
	input wire logic op_valid,
	input wire psr_op_t op_code,
	input wire logic res_valid,
	input wire logic [PSR_REG_W-1:0] res_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic st_q = 1'h0;
	logic [7:0] mem [8];
	always_ff @(posedge ref_clk)
	begin
		if (ce)
		begin
			st_q <= op_valid && op_code == PSR_OP_STORE_Q;
			if (st_q && res_valid)
			begin
				for (int k = 0; k < 8; k++)
					mem[k] <= res_data[8*k+:8];
			end
		end
	end
endmodule

// >>> tb.sv
// self-checking bench for the packed simd register file
module tb
	import psr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [63:0] OPA = 64'h807F_0001_FF10_2030;
	localparam logic [63:0] OPB = 64'h0101_FFFF_0110_1010;
	typedef struct {psr_op_t c; psr_size_t s; logic [63:0] e;} psr_row_t;
	logic ref_clk = 1'h0, srst = 1'h1, ce = 1'h1, op_valid = 1'h0;
	logic src_is_ext = 1'h0, fp_wr_en = 1'h0, res_valid;
	psr_op_t op_code = PSR_OP_ADD;
	psr_size_t op_size = PSR_SZ_BYTE;
	logic [2:0] dst_idx = 3'h0, src_idx = 3'h0;
	logic [2:0] fp_wr_idx = 3'h0, fp_rd_idx = 3'h0;
	logic [63:0] ext_data = 64'hDEAD_BEEF_1234_5678;
	logic [63:0] fp_wr_data = 64'h0, res_data, fp_rd_data;
	int fails = 0, check_count = 0;
	psr_row_t rows [18] = '{
		'{PSR_OP_ADD, PSR_SZ_BYTE, 64'h8180_FF00_0020_3040},
		'{PSR_OP_ADD, PSR_SZ_WORD, 64'h8180_0000_0020_3040},
		'{PSR_OP_ADD, PSR_SZ_DWORD, 64'h8181_0000_0020_3040},
		'{PSR_OP_ADD, PSR_SZ_QWORD, 64'h8181_0001_0020_3040},
		'{PSR_OP_ADD_SS, PSR_SZ_BYTE, 64'h817F_FF00_0020_3040},
		'{PSR_OP_ADD_US, PSR_SZ_BYTE, 64'h8180_FFFF_FF20_3040},
		'{PSR_OP_SUB, PSR_SZ_BYTE, 64'h7F7E_0102_FE00_1020},
		'{PSR_OP_SUB_SS, PSR_SZ_BYTE, 64'h807E_0102_FE00_1020},
		'{PSR_OP_SUB_US, PSR_SZ_BYTE, 64'h7F7E_0000_FE00_1020},
		'{PSR_OP_SUB, PSR_SZ_DWORD, 64'h7F7D_0002_FE00_1020},
		'{PSR_OP_AND, PSR_SZ_QWORD, 64'h0001_0001_0110_0010},
		'{PSR_OP_ANDN, PSR_SZ_QWORD, 64'h0100_FFFE_0000_1000},
		'{PSR_OP_OR, PSR_SZ_QWORD, 64'h817F_FFFF_FF10_3030},
		'{PSR_OP_XOR, PSR_SZ_QWORD, 64'h817E_FFFE_FE00_3020},
		'{PSR_OP_CMP_EQ, PSR_SZ_BYTE, 64'h0000_0000_00FF_0000},
		'{PSR_OP_CMP_GT, PSR_SZ_BYTE, 64'h00FF_FFFF_0000_FFFF},
		'{PSR_OP_MOVE_Q, PSR_SZ_QWORD, OPB},
		'{PSR_OP_MOVE_D, PSR_SZ_DWORD, 64'h0000_0000_0110_1010}};

	psr_register_file psr_register_file_i (.ref_clk(ref_clk), .srst(srst),
		.ce(ce), .op_valid(op_valid), .op_code(op_code), .op_size(op_size),
		.dst_idx(dst_idx), .src_idx(src_idx), .src_is_ext(src_is_ext),
		.ext_data(ext_data), .fp_wr_en(fp_wr_en), .fp_wr_idx(fp_wr_idx),
		.fp_wr_data(fp_wr_data), .fp_rd_idx(fp_rd_idx),
		.res_valid(res_valid), .res_data(res_data), .fp_rd_data(fp_rd_data));
	psr_lsu_model psr_lsu_model_i (.ref_clk(ref_clk), .ce(ce),
		.op_valid(op_valid), .op_code(op_code), .res_valid(res_valid),
		.res_data(res_data));

	// ----------------------------------------
	// bus tasks and comparison
	// ----------------------------------------
	task automatic chk(input string n, input logic [63:0] s, e);
		check_count++;
		if (s !== e)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic fpw(input logic [2:0] i, input logic [63:0] d);
		@(posedge ref_clk);
		fp_wr_en <= 1'h1;
		fp_wr_idx <= i;
		fp_wr_data <= d;
		@(posedge ref_clk);
		fp_wr_en <= 1'h0;
	endtask
	task automatic fpr(input logic [2:0] i, input logic [63:0] e);
		@(posedge ref_clk);
		fp_rd_idx <= i;
		@(posedge ref_clk);
		#1;
		chk("fp_rd_data", fp_rd_data, e);
	endtask
	task automatic op(input psr_op_t c, input psr_size_t s,
		input logic [2:0] d, si, input logic x, input logic [63:0] e);
		@(posedge ref_clk);
		op_valid <= 1'h1;
		op_code <= c;
		op_size <= s;
		dst_idx <= d;
		src_idx <= si;
		src_is_ext <= x;
		@(posedge ref_clk);
		op_valid <= 1'h0;
		#1;
		chk("res_valid", 64'(res_valid), 64'h1);
		chk(c.name(), res_data, e);
	endtask
	task automatic tally_and_finish();
		if (fails == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial
	begin
		forever #20 ref_clk = ~ref_clk;
	end
	initial
	begin
		repeat (4000) @(posedge ref_clk);
		fails++;
		tally_and_finish();
	end
	initial
	begin
		repeat (6) @(posedge ref_clk);
		srst <= 1'h0;
		fpr(3'h7, 64'h0);
		foreach (rows[r])
		begin
			fpw(3'h1, OPA);
			fpw(3'h2, OPB);
			op(rows[r].c, rows[r].s, 3'h1, 3'h2, 1'h0, rows[r].e);
			fpr(3'h1, rows[r].e);
		end
		fpw(3'h7, OPA);
		op(PSR_OP_MOVE_Q, PSR_SZ_QWORD, 3'h0, 3'h7, 1'h0, OPA);
		fpr(3'h0, OPA);
		fpw(3'h3, 64'hFFFF_FFFF_FFFF_FFFF);
		op(PSR_OP_MOVE_D, PSR_SZ_DWORD, 3'h3, 3'h0, 1'h1, 64'h1234_5678);
		fpr(3'h3, 64'h0000_0000_1234_5678);
		fpw(3'h4, 64'h8877_6655_4433_2211);
		op(PSR_OP_STORE_Q, PSR_SZ_QWORD, 3'h4, 3'h4, 1'h0, 64'h8877_6655_4433_2211);
		@(posedge ref_clk);
		#1;
		for (int k = 0; k < 8; k++)
			chk("mem", 64'(psr_lsu_model_i.mem[k]), 64'(8'h11 * (k + 1)));
		op(PSR_OP_STORE_D, PSR_SZ_DWORD, 3'h4, 3'h4, 1'h0, 64'h4433_2211);
		fpr(3'h4, 64'h8877_6655_4433_2211);
		// clock enable low: neither the op nor the fp write may land
		fpw(3'h5, OPA);
		@(posedge ref_clk);
		ce <= 1'h0;
		op_valid <= 1'h1;
		op_code <= PSR_OP_MOVE_Q;
		dst_idx <= 3'h5;
		src_idx <= 3'h2;
		fp_wr_en <= 1'h1;
		fp_wr_idx <= 3'h5;
		fp_wr_data <= PSR_REG_RESET;
		repeat (2) @(posedge ref_clk);
		#1;
		chk("res_valid", 64'(res_valid), 64'h0);
		chk("res_data", res_data, 64'h4433_2211);
		chk("fp_rd_data", fp_rd_data, 64'h8877_6655_4433_2211);
		@(posedge ref_clk);
		ce <= 1'h1;
		op_valid <= 1'h0;
		fp_wr_en <= 1'h0;
		fpr(3'h5, OPA);
		// reset in mid-run clears storage and outputs
		@(posedge ref_clk);
		srst <= 1'h1;
		@(posedge ref_clk);
		srst <= 1'h0;
		#1;
		chk("res_valid", 64'(res_valid), 64'h0);
		chk("res_data", res_data, PSR_REG_RESET);
		chk("fp_rd_data", fp_rd_data, PSR_REG_RESET);
		fpr(3'h5, PSR_REG_RESET);
		tally_and_finish();
	end
endmodule
